// File: rivm_pkg.sv
// ----------------------------------------------------------------
// constants for reset and interrupt vector address generation
// ----------------------------------------------------------------
package rivm_pkg;

	// program word address width (4k words of flash)
	localparam int ADDR_W = 12;
	// interrupt sources, vector table entries after the reset word
	localparam int NUM_IRQ = 25;
	localparam int IDX_W = 5;
	// number of system reset sources and their bit positions
	localparam int NUM_RST_SRC = 4;
	localparam int RST_SRC_PIN = 0;
	localparam int RST_SRC_POWER_ON = 1;
	localparam int RST_SRC_BROWN_OUT = 2;
	localparam int RST_SRC_WATCHDOG = 3;

	// fixed addresses of the application section table
	localparam logic [ADDR_W-1:0] RESET_VEC_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] TABLE_OFFSET = 12'h001;

	// boot reset select fuse encoding
	localparam logic FUSE_PROGRAMMED = 1'b0;
	localparam logic FUSE_UNPROGRAMMED = 1'b1;

	// vector number of the reset entry, interrupt entries follow it
	localparam logic [IDX_W-1:0] RESET_VEC_NUM = 5'h01;
	localparam logic [IDX_W-1:0] FIRST_IRQ_VEC_NUM = 5'h02;

	// request line index of each source; table address is index + 1
	localparam int IRQ_EXTERNAL_REQUEST_0 = 0;
	localparam int IRQ_EXTERNAL_REQUEST_1 = 1;
	localparam int IRQ_PIN_CHANGE_REQUEST_0 = 2;
	localparam int IRQ_PIN_CHANGE_REQUEST_1 = 3;
	localparam int IRQ_PIN_CHANGE_REQUEST_2 = 4;
	localparam int IRQ_WATCHDOG_TIMEOUT_REQUEST = 5;
	localparam int IRQ_TIMER_B8_COMPARE_A = 6;
	localparam int IRQ_TIMER_B8_COMPARE_B = 7;
	localparam int IRQ_TIMER_B8_OVERFLOW = 8;
	localparam int IRQ_TIMER_W16_CAPTURE = 9;
	localparam int IRQ_TIMER_W16_COMPARE_A = 10;
	localparam int IRQ_TIMER_W16_COMPARE_B = 11;
	localparam int IRQ_TIMER_W16_OVERFLOW = 12;
	localparam int IRQ_TIMER_A8_COMPARE_A = 13;
	localparam int IRQ_TIMER_A8_COMPARE_B = 14;
	localparam int IRQ_TIMER_A8_OVERFLOW = 15;
	localparam int IRQ_SERIAL_TRANSFER_COMPLETE = 16;
	localparam int IRQ_RX_COMPLETE = 17;
	localparam int IRQ_TX_BUFFER_EMPTY = 18;
	localparam int IRQ_TX_COMPLETE = 19;
	localparam int IRQ_CONVERSION_COMPLETE = 20;
	localparam int IRQ_DATA_NVM_READY = 21;
	localparam int IRQ_ANALOG_COMPARATOR = 22;
	localparam int IRQ_TWO_WIRE_SERIAL_EVENT = 23;
	localparam int IRQ_PROGRAM_STORE_READY = 24;

endpackage : rivm_pkg

// File: rivm_prio_enc.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// lowest-index-first priority encoder over the request lines
// ----------------------------------------------------------------
module rivm_prio_enc
(
	input wire logic [rivm_pkg::NUM_IRQ-1:0] req_in,
	output logic valid_out,
	output logic [rivm_pkg::IDX_W-1:0] idx_out
);

	// scan from the top so the lowest set line is the one kept
	always_comb
	begin
		valid_out = 1'b0;
		idx_out = '0;
		for (int i = rivm_pkg::NUM_IRQ - 1; i >= 0; i--)
		begin
			if (req_in[i])
			begin
				valid_out = 1'b1;
				idx_out = i[rivm_pkg::IDX_W-1:0];
			end
		end
	end

endmodule : rivm_prio_enc

// File: rivm_vec_addr.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// interrupt table start and vector address arithmetic
// ----------------------------------------------------------------
module rivm_vec_addr
(
	input wire logic to_boot_in,
	input wire logic [rivm_pkg::ADDR_W-1:0] boot_addr_in,
	input wire logic [rivm_pkg::IDX_W-1:0] idx_in,
	output logic [rivm_pkg::ADDR_W-1:0] table_base_out,
	output logic [rivm_pkg::ADDR_W-1:0] vec_addr_out
);

	// word address of interrupt entry idx for a given table origin
	function automatic logic [rivm_pkg::ADDR_W-1:0] entry_addr(
		input logic [rivm_pkg::ADDR_W-1:0] origin,
		input logic [rivm_pkg::IDX_W-1:0] idx
	);
		entry_addr = rivm_pkg::ADDR_W'(origin + rivm_pkg::TABLE_OFFSET
			+ rivm_pkg::ADDR_W'(idx));
	endfunction : entry_addr

	// table origin is word zero or the boot section start
	always_comb
	begin
		if (to_boot_in)
		begin
			table_base_out = entry_addr(boot_addr_in, '0);
			vec_addr_out = entry_addr(boot_addr_in, idx_in);
		end
		else
		begin
			table_base_out = entry_addr(rivm_pkg::RESET_VEC_ADDR, '0);
			vec_addr_out = entry_addr(rivm_pkg::RESET_VEC_ADDR, idx_in);
		end
	end

endmodule : rivm_vec_addr

// File: rivm_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - every system reset (pin, power-on, brown-out, watchdog) restarts the core at the reset vector, word 0x000 with the fuse unprogrammed.
// - external requests 0 and 1 vector to table words 0x001 and 0x002.
// - pin change requests 0, 1 and 2 vector to 0x003, 0x004 and 0x005.
// - the watchdog time-out interrupt, not its system reset, vectors to 0x006.
// - the second 8-bit timer compare A, compare B and overflow vector to 0x007 to 0x009.
// - the 16-bit timer capture, compare A, compare B and overflow vector to 0x00a to 0x00d.
// - the first 8-bit timer compare A, compare B and overflow vector to 0x00e to 0x010.
// - the serial transfer complete event vectors to 0x011.
// - receive complete, transmit buffer empty and transmit complete vector to 0x012 to 0x014.
// - conversion done, nvm ready, comparator, two-wire and store ready go to 0x015 to 0x019.
// - with the boot reset fuse programmed, reset starts at the boot loader address.
// - with the table moved to boot, each vector is its table address plus the boot start.
// - the table starts at 0x001, or boot address plus 0x001, whatever the reset vector.
// - a fuse value of 1 is unprogrammed (reset at 0x000) and 0 is programmed (boot address).
// - vectors are fetched only when an enabled interrupt is taken, so idle table words are free.
module rivm_top
(
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// asynchronous reset causes: pin, power-on, brown-out, watchdog system reset
	input wire logic [rivm_pkg::NUM_RST_SRC-1:0] reset_source_in,
	// fuse level and boot section start, sampled while in reset
	input wire logic boot_reset_select_fuse_in,
	input wire logic [rivm_pkg::ADDR_W-1:0] boot_reset_addr_in,
	// table relocation bit of the core control register
	input wire logic vector_table_to_boot_in,
	// global interrupt enable of the core
	input wire logic irq_global_enable_in,
	// enabled peripheral request lines, held until acknowledged
	input wire logic [rivm_pkg::NUM_IRQ-1:0] irq_req_in,
	// core is at an instruction boundary and takes a pending interrupt
	input wire logic irq_take_in,
	output logic irq_pending_out,
	output logic pc_load_out,
	output logic [rivm_pkg::ADDR_W-1:0] pc_addr_out,
	output logic [rivm_pkg::IDX_W-1:0] vec_num_out,
	output logic [rivm_pkg::NUM_IRQ-1:0] irq_ack_out,
	output logic core_hold_out,
	output logic [rivm_pkg::NUM_RST_SRC-1:0] reset_cause_out,
	output logic [rivm_pkg::ADDR_W-1:0] reset_vec_out,
	output logic [rivm_pkg::ADDR_W-1:0] table_base_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------

	typedef enum logic [1:0]
	{
		ST_RESET,
		ST_RESET_FETCH,
		ST_RUN
	} rivm_phase_t;

	typedef struct packed
	{
		rivm_phase_t phase;
		logic [rivm_pkg::NUM_RST_SRC-1:0] src_meta;
		logic [rivm_pkg::NUM_RST_SRC-1:0] src_sync;
		logic fuse;
		logic [rivm_pkg::ADDR_W-1:0] boot_addr;
		logic pc_load;
		logic [rivm_pkg::ADDR_W-1:0] pc_addr;
		logic [rivm_pkg::IDX_W-1:0] vec_num;
		logic [rivm_pkg::NUM_IRQ-1:0] ack;
		logic [rivm_pkg::NUM_RST_SRC-1:0] cause;
	} rivm_state_t;

	localparam rivm_state_t RESET_STATE = '{
		phase: ST_RESET,
		src_meta: '0,
		src_sync: '0,
		fuse: rivm_pkg::FUSE_UNPROGRAMMED,
		boot_addr: rivm_pkg::RESET_VEC_ADDR,
		pc_load: 1'b0,
		pc_addr: rivm_pkg::RESET_VEC_ADDR,
		vec_num: '0,
		ack: '0,
		cause: '0
	};

	rivm_state_t s_q;
	rivm_state_t s_d;

	// ----------------------------------------------------------------
	// request selection and address arithmetic
	// ----------------------------------------------------------------

	logic req_valid;
	logic [rivm_pkg::IDX_W-1:0] req_idx;
	logic [rivm_pkg::ADDR_W-1:0] irq_vec_addr;
	logic [rivm_pkg::ADDR_W-1:0] reset_addr;
	logic in_reset;
	logic accept;

	// lowest request line wins when several are pending
	rivm_prio_enc u_prio
	(
		.req_in(irq_req_in),
		.valid_out(req_valid),
		.idx_out(req_idx)
	);

	// table entry is origin plus 0x001 plus line index
	rivm_vec_addr u_addr
	(
		.to_boot_in(vector_table_to_boot_in),
		.boot_addr_in(s_q.boot_addr),
		.idx_in(req_idx),
		.table_base_out(table_base_out),
		.vec_addr_out(irq_vec_addr)
	);

	// reset vector follows only the fuse, never the table relocation bit
	always_comb
	begin
		if (s_q.fuse == rivm_pkg::FUSE_PROGRAMMED)
		begin
			reset_addr = s_q.boot_addr;
		end
		else
		begin
			reset_addr = rivm_pkg::RESET_VEC_ADDR;
		end
	end

	// any synchronised reset cause holds the block in reset
	assign in_reset = |s_q.src_sync;

	// a vector is fetched only for a taken, enabled request
	assign accept = (s_q.phase == ST_RUN) && !in_reset && irq_global_enable_in
		&& req_valid && irq_take_in && !s_q.pc_load;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------

	// reset sequencing and interrupt acceptance
	always_comb
	begin
		s_d = s_q;
		// two-stage synchroniser for the external reset causes
		s_d.src_meta = reset_source_in;
		s_d.src_sync = s_q.src_meta;
		// load strobe and acknowledge are single-cycle pulses
		s_d.pc_load = 1'b0;
		s_d.ack = '0;
		unique case (s_q.phase)
			ST_RESET:
			begin
				// straps are sampled every cycle in reset, last value kept
				s_d.fuse = boot_reset_select_fuse_in;
				s_d.boot_addr = boot_reset_addr_in;
				if (!in_reset)
				begin
					s_d.phase = ST_RESET_FETCH;
				end
			end
			ST_RESET_FETCH:
			begin
				// first fetch after any reset goes to the reset vector
				s_d.pc_load = 1'b1;
				s_d.pc_addr = reset_addr;
				s_d.vec_num = rivm_pkg::RESET_VEC_NUM;
				s_d.phase = ST_RUN;
			end
			ST_RUN:
			begin
				if (accept)
				begin
					// load the vector and clear the chosen request
					s_d.pc_load = 1'b1;
					s_d.pc_addr = irq_vec_addr;
					s_d.vec_num = rivm_pkg::IDX_W'(req_idx
						+ rivm_pkg::FIRST_IRQ_VEC_NUM);
					s_d.ack[req_idx] = 1'b1;
				end
			end
		endcase
		// a reset cause overrides everything and is recorded
		if (in_reset)
		begin
			s_d.phase = ST_RESET;
			s_d.pc_load = 1'b0;
			s_d.ack = '0;
			s_d.cause = s_q.src_sync;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------

	// single register bank, synchronous reset
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			s_q <= RESET_STATE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	// pending and table base are combinational from inputs, the rest come from flip-flops
	assign irq_pending_out = (s_q.phase == ST_RUN) && !in_reset
		&& irq_global_enable_in && req_valid && !s_q.pc_load;
	assign pc_load_out = s_q.pc_load;
	assign pc_addr_out = s_q.pc_addr;
	assign vec_num_out = s_q.vec_num;
	assign irq_ack_out = s_q.ack;
	assign core_hold_out = (s_q.phase == ST_RESET); // core stalls in ST_RESET, released one cycle before the reset vector load
	assign reset_cause_out = s_q.cause;
	assign reset_vec_out = reset_addr;

endmodule : rivm_top

// File: rivm_asserts.sv
`timescale 1ns/1ns
// ------------------------------------------------
// port checker for the vector map
// ------------------------------------------------
module rivm_asserts
(
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic vector_table_to_boot_in,
	input wire logic [24:0] irq_req_in,
	input wire logic irq_take_in,
	input wire logic irq_pending_out,
	input wire logic pc_load_out,
	input wire logic [11:0] pc_addr_out,
	input wire logic [4:0] vec_num_out,
	input wire logic [24:0] irq_ack_out,
	input wire logic core_hold_out,
	input wire logic [11:0] reset_vec_out,
	input wire logic [11:0] table_base_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	// an accept happens where pending meets take
	wire logic taken = irq_pending_out && irq_take_in;

	AST_LOAD_PULSE: assert property (pc_load_out |=> !pc_load_out)
		else $error("load strobe too long");
	AST_TAKE_ACK: assert property (taken |=> pc_load_out && irq_ack_out ==
		($past(irq_req_in) & (~$past(irq_req_in) + 25'h1))) else $error("wrong ack");
	AST_VEC_ADDR: assert property (taken |=> pc_addr_out ==
		$past(table_base_out) + {7'h00, vec_num_out} - 12'h002) else $error("wrong vector");
	AST_BASE_APP: assert property (!vector_table_to_boot_in |-> table_base_out == 12'h001)
		else $error("wrong table base");
	AST_RST_LOAD: assert property ($fell(core_hold_out) |=> pc_load_out &&
		vec_num_out == 5'h01 && pc_addr_out == reset_vec_out) else $error("no reset load");
	AST_HOLD_QUIET: assert property (core_hold_out |-> !irq_pending_out && irq_ack_out == '0)
		else $error("activity in reset");
	AST_ACK_CAUSE: assert property (irq_ack_out != '0 |-> $past(irq_take_in) &&
		$past(irq_pending_out)) else $error("ack without take");
	AST_NO_BACK2BACK: assert property (pc_load_out |-> !irq_pending_out)
		else $error("pending during load");
	// main scenarios
	COV_RESET: cover property ($fell(core_hold_out) ##1 pc_load_out);
	COV_BOOT: cover property (taken && vector_table_to_boot_in);
	COV_LAST: cover property (pc_load_out && vec_num_out == 5'h1a);
endmodule : rivm_asserts

// File: rivm_core_model.sv
`timescale 1ns/1ns
// ------------------------------------------------
// requesting peripherals and fetching core
// ------------------------------------------------
module rivm_core_model
(
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic [24:0] post_in,
	input wire logic [24:0] irq_ack_in,
	input wire logic take_en_in,
	output logic [24:0] irq_req_out,
	output logic irq_take_out
);
	// lines stay up until their own acknowledge pulse
	always_ff @(posedge mclk_in)
		irq_req_out <= sys_rst_in ? '0 : (irq_req_out | post_in) & ~irq_ack_in;
	// core offers a boundary whenever allowed
	assign irq_take_out = take_en_in;
endmodule : rivm_core_model

// File: reset_irq_vector_map_bench.sv
`timescale 1ns/1ns
// ------------------------------------------------
// bench for the vector map
// ------------------------------------------------
module reset_irq_vector_map_bench;
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [3:0] src = 4'h0;
	logic fuse = 1'b1;
	logic vtb = 1'b0;
	logic gen = 1'b0;
	logic take_en = 1'b0;
	logic [24:0] post = '0;
	logic [24:0] req, ack;
	logic take, pend, load, hold;
	logic [11:0] addr, rvec, base;
	logic [4:0] vnum;
	logic [3:0] cause;
	int mismatches = 0;
	int tests_run = 0;

	// clock of 50 ns
	initial forever #25 mclk_in = ~mclk_in;

	rivm_top u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reset_source_in(src),
		.boot_reset_select_fuse_in(fuse), .boot_reset_addr_in(12'hc00),
		.vector_table_to_boot_in(vtb), .irq_global_enable_in(gen), .irq_req_in(req),
		.irq_take_in(take), .irq_pending_out(pend), .pc_load_out(load), .pc_addr_out(addr),
		.vec_num_out(vnum), .irq_ack_out(ack), .core_hold_out(hold), .reset_cause_out(cause),
		.reset_vec_out(rvec), .table_base_out(base));
	rivm_core_model u_core (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .post_in(post),
		.irq_ack_in(ack), .take_en_in(take_en), .irq_req_out(req), .irq_take_out(take));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// waits a bounded span for the load strobe
	task automatic wait_load();
		int n;
		n = 0;
		@(negedge mclk_in);
		while (load !== 1'b1 && n < 40)
		begin
			@(negedge mclk_in);
			n++;
		end
		chk(load, 1);
	endtask : wait_load

	task automatic reset_run(input logic f);
		@(posedge mclk_in);
		sys_rst_in <= 1'b1;
		fuse <= f;
		repeat (5) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		wait_load();
		chk(addr, f ? 12'h000 : 12'hc00);
		chk(vnum, 5'h01);
		chk(rvec, f ? 12'h000 : 12'hc00);
		chk(hold, 1'b0);
	endtask : reset_run

	task automatic source_run(input int s);
		@(posedge mclk_in);
		src <= 4'h1 << s;
		repeat (3) @(posedge mclk_in);
		src <= 4'h0;
		wait_load();
		chk(addr, 12'hc00);
		chk(cause, 4'h1 << s);
	endtask : source_run

	task automatic post_req(input logic [24:0] v);
		@(posedge mclk_in);
		post <= v;
		@(posedge mclk_in);
		post <= '0;
	endtask : post_req

	// every source in turn, table in either section
	task automatic take_all(input logic b);
		logic [11:0] bs;
		bs = b ? 12'hc01 : 12'h001;
		@(posedge mclk_in);
		vtb <= b;
		@(posedge mclk_in);
		gen <= 1'b1;
		take_en <= 1'b1;
		for (int i = 0; i < 25; i++)
		begin
			post_req(25'h1 << i);
			wait_load();
			chk(addr, bs + 12'(i));
			chk(ack, 25'h1 << i);
			chk(base, bs);
		end
		@(posedge mclk_in);
		gen <= 1'b0;
	endtask : take_all

	// masked requests, then lowest number first
	task automatic prio_masked();
		int n;
		n = 0;
		post_req(25'h1000008);
		repeat (8)
		begin
			@(negedge mclk_in);
			n += load;
		end
		chk(n, 0);
		chk(pend, 1'b0);
		@(posedge mclk_in);
		gen <= 1'b1;
		wait_load();
		chk(addr, 12'h004);
		wait_load();
		chk(addr, 12'h019);
	endtask : prio_masked

	// main sequence
	initial
	begin
		reset_run(1'b1);
		reset_run(1'b0);
		take_all(1'b1);
		take_all(1'b0);
		prio_masked();
		for (int s = 0; s < 4; s++)
			source_run(s);
		print_verdict();
	end

	// watchdog against a hang
	initial
	begin
		#400000;
		mismatches++;
		print_verdict();
	end
endmodule : reset_irq_vector_map_bench

bind rivm_top rivm_asserts u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
	.vector_table_to_boot_in(vector_table_to_boot_in), .irq_req_in(irq_req_in),
	.irq_take_in(irq_take_in), .irq_pending_out(irq_pending_out), .pc_load_out(pc_load_out),
	.pc_addr_out(pc_addr_out), .vec_num_out(vec_num_out), .irq_ack_out(irq_ack_out),
	.core_hold_out(core_hold_out), .reset_vec_out(reset_vec_out),
	.table_base_out(table_base_out));
